// ==== logic/btl_pkg.sv ====
package btl_pkg;

  // Loader sequencing states
  typedef enum logic [9:0] {
    ST_IDLE = 10'h001,
    ST_PTR  = 10'h002,
    ST_HDR  = 10'h004,
    ST_SIZE = 10'h008,
    ST_PAGE = 10'h010,
    ST_DEST = 10'h020,
    ST_RD   = 10'h040,
    ST_WR   = 10'h080,
    ST_FOOT = 10'h100,
    ST_JUMP = 10'h200
  } btl_state_t;

  // Memory spaces on the parallel interface
  localparam logic [1:0] SP_PROG = 2'h0;
  localparam logic [1:0] SP_DATA = 2'h1;
  localparam logic [1:0] SP_IO = 2'h2;

  // Register byte offsets
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_STATUS = 8'h04;
  localparam logic [7:0] OFF_SRC_PAGE = 8'h08;
  localparam logic [7:0] OFF_WAIT = 8'h0C;
  localparam logic [7:0] OFF_BANK = 8'h10;
  localparam logic [7:0] OFF_ENTRY_HI = 8'h14;
  localparam logic [7:0] OFF_ENTRY_LO = 8'h18;
  localparam logic [7:0] OFF_BLOCKS = 8'h1C;
  localparam logic [7:0] OFF_PROT_LO = 8'h20;
  localparam logic [7:0] OFF_PROT_HI = 8'h24;
  localparam logic [7:0] OFF_FOOTER = 8'h28;

  // Control bit positions
  localparam int CTRL_START = 0;
  localparam int CTRL_STAGE2 = 1;
  localparam int CTRL_PTR_IO = 2;
  localparam int CTRL_FOOT_EN = 3;

  // Status bit positions
  localparam int STAT_BUSY = 0;
  localparam int STAT_DONE = 1;
  localparam int STAT_BAD_HDR = 2;
  localparam int STAT_PROT_HIT = 3;
  localparam int STAT_FLASH = 4;
  localparam int STAT_INTR_DIS = 5;
  localparam int STAT_OVERLAY = 6;

  // Table layout and fixed addresses
  localparam logic [15:0] TABLE_TAG = 16'h10AA;
  localparam logic [15:0] PTR_ADDR = 16'hFFFF;
  localparam logic [15:0] EXT_UPPER_BASE = 16'h8000;
  localparam logic [15:0] END_SIZE = 16'h0000;
  localparam logic [2:0] HDR_LAST = 3'h4;
  localparam int EXT_PAGES = 8;

  // Reset values
  localparam logic [15:0] WAIT_RST = 16'h7FFF;
  localparam logic [15:0] BANK_RST = 16'h0000;
  localparam logic [15:0] PROT_LO_RST = 16'h0000;
  localparam logic [15:0] PROT_HI_RST = 16'h0000;
  localparam logic [2:0] SRC_PAGE_RST = 3'h1;
  localparam logic FLASH_RST = 1'b1;

  // Timing: strobe extra cycles for the two-flop read path
  localparam logic [3:0] SYNC_LAT = 4'h2;

endpackage

// ==== logic/btl_sync.sv ====
`timescale 1ns/1ps
module btl_sync #(
  parameter int W = 16
) (
  // Clock and reset
  input wire logic clock,
  input wire logic resetn,
  // Pin side and synchronised side
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);

  logic [W-1:0] meta_reg;

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      meta_reg <= '0;
      q <= '0;
    end else begin
      meta_reg <= d;
      q <= meta_reg;
    end
  end

endmodule

// ==== logic/btl_addr_cnt.sv ====
`timescale 1ns/1ps
module btl_addr_cnt (
  // Clock and reset
  input wire logic clock,
  input wire logic resetn,
  // Load has priority over step
  input wire logic load,
  input wire logic [15:0] load_val,
  input wire logic inc,
  output logic [15:0] addr
);

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      addr <= 16'h0000;
    end else if (load) begin
      addr <= load_val;
    end else if (inc) begin
      addr <= addr + 16'h0001;
    end
  end

endmodule

// ==== logic/btl_loader.sv ====
// Overview of operation
// RULE1: Parallel boot reads data space, writes program
// RULE2: Every block lands in program memory
// RULE3: Table start comes from I/O or data FFFF
// RULE4: First-stage table lies within 4000h to FFFFh
// RULE5: Board with hole limits table to 8000h+
// RULE6: Eight extended program pages hold large tables
// RULE7: Extended-page tables start in upper 32K
// RULE8: Each extended-page table at most 32K words
// RULE9: Select bit: 1 flash, 0 SRAM, resets 1
// RULE10: Flash before each read, SRAM before write
// RULE11: Parse headers, copy, spare protected region
// RULE12: First word must equal 10AAh
// RULE13: Words two, three load wait and bank
// RULE14: Words four, five form 23-bit entry
// RULE15: Block is size, page, destination, data words
// RULE16: Any block count, terminator, optional footer
// RULE17: Jump to entry point after load
// RULE18: Size word zero ends the table
// RULE19: Start: interrupts off, overlay on, seven waits
// RULE20: Source and destination step one per word
// RULE21: Second stage ends with SRAM selected
`timescale 1ns/1ps
module btl_loader
  import btl_pkg::*;
(
  // Clock and reset
  input wire logic clock,
  input wire logic resetn,
  // Register port
  input wire logic [7:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [15:0] reg_rdata,
  // Parallel memory interface
  output logic [22:0] mem_addr,
  output logic [1:0] mem_space,
  output logic mem_rd,
  output logic mem_wr,
  output logic [15:0] mem_wdata,
  output logic mem_data_oe,
  input wire logic [15:0] mem_rdata,
  output logic ext_mem_flash_select,
  // Processor handoff
  output logic intr_disable,
  output logic overlay,
  output logic jump,
  output logic [22:0] entry_addr
);

  btl_state_t state_reg;
  logic stage2_reg, ptr_io_reg, foot_en_reg;
  logic done_reg, bad_hdr_reg, prot_hit_reg;
  logic [2:0] src_page_reg, hdr_idx_reg;
  logic [15:0] wait_reg, bank_reg, entry_lo_reg, prot_lo_reg, prot_hi_reg;
  logic [15:0] footer_reg, blocks_reg, size_left_reg, data_reg;
  logic [6:0] entry_hi_reg, dst_page_reg;
  logic acc_active_reg, acc_done_reg;
  logic [3:0] acc_cnt_reg;
  logic [15:0] rd_word_reg, sync_rdata, src_ptr, dst_ptr;
  logic start, need_rd, need_wr, sel_ok, acc_go, prot_blk, skip_wr;
  logic src_load, src_inc, dst_load, dst_inc;
  logic [15:0] src_val;
  logic [1:0] acc_space;
  logic [22:0] acc_addr;
  logic [3:0] acc_ws;

  btl_sync #(.W(16)) u_rd_sync (
    .clock(clock),
    .resetn(resetn),
    .d(mem_rdata),
    .q(sync_rdata)
  );

  btl_addr_cnt u_src (
    .clock(clock),
    .resetn(resetn),
    .load(src_load),
    .load_val(src_val),
    .inc(src_inc),
    .addr(src_ptr)
  );

  btl_addr_cnt u_dst (
    .clock(clock),
    .resetn(resetn),
    .load(dst_load),
    .load_val(rd_word_reg),
    .inc(dst_inc),
    .addr(dst_ptr)
  );

  // Wait field per space and address half
  function automatic logic [2:0] ws_of(input logic [1:0] sp, input logic hi,
                                       input logic [15:0] w);
    logic [2:0] r;
    r = w[14:12];
    if (sp == SP_PROG) begin
      r = hi ? w[5:3] : w[2:0];
    end else if (sp == SP_DATA) begin
      r = hi ? w[11:9] : w[8:6];
    end
    return r;
  endfunction

  assign start = reg_wr && (reg_addr == OFF_CTRL) && reg_wdata[CTRL_START]
                 && (state_reg == ST_IDLE);
  assign prot_blk = (dst_page_reg == 7'h00) && (dst_ptr >= prot_lo_reg)
                    && (dst_ptr <= prot_hi_reg);
  assign skip_wr = (state_reg == ST_WR) && prot_blk; // see RULE11

  always_comb begin
    need_rd = 1'b0;
    case (state_reg)
      ST_PTR, ST_HDR, ST_SIZE, ST_PAGE, ST_DEST, ST_RD, ST_FOOT: need_rd = 1'b1;
      default: need_rd = 1'b0;
    endcase
    need_wr = (state_reg == ST_WR) && !prot_blk;
    // Extended pages are program space; first stage reads data space
    if (state_reg == ST_PTR) begin
      acc_space = ptr_io_reg ? SP_IO : SP_DATA; // see RULE3
      acc_addr = {7'h00, PTR_ADDR};
    end else if (need_wr) begin
      acc_space = SP_PROG; // see RULE2
      acc_addr = {dst_page_reg, dst_ptr};
    end else begin
      acc_space = stage2_reg ? SP_PROG : SP_DATA; // see RULE1
      acc_addr = {stage2_reg ? {4'h0, src_page_reg} : 7'h00, src_ptr}; // see RULE6
    end
    // Flash for reads, SRAM for writes, one cycle ahead
    sel_ok = !stage2_reg || (need_wr ? !ext_mem_flash_select
                                     : ext_mem_flash_select); // see RULE10
    acc_go = (need_rd || need_wr) && !acc_active_reg && !acc_done_reg && sel_ok;
    acc_ws = {1'b0, ws_of(acc_space, acc_addr[15], wait_reg)};
  end

  // Access engine: strobe spans the wait states plus the sync latency
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      acc_active_reg <= 1'b0;
      acc_done_reg <= 1'b0;
      acc_cnt_reg <= 4'h0;
      mem_addr <= 23'h000000;
      mem_space <= SP_DATA;
      mem_rd <= 1'b0;
      mem_wr <= 1'b0;
      mem_wdata <= 16'h0000;
      mem_data_oe <= 1'b0;
      rd_word_reg <= 16'h0000;
    end else begin
      acc_done_reg <= 1'b0;
      if (acc_go) begin
        acc_active_reg <= 1'b1;
        acc_cnt_reg <= acc_ws + SYNC_LAT; // see RULE19
        mem_addr <= acc_addr;
        mem_space <= acc_space;
        mem_rd <= need_rd;
        mem_wr <= need_wr;
        mem_wdata <= data_reg;
        mem_data_oe <= need_wr;
      end else if (acc_active_reg) begin
        if (acc_cnt_reg == 4'h0) begin
          acc_active_reg <= 1'b0;
          acc_done_reg <= 1'b1;
          rd_word_reg <= sync_rdata;
          mem_rd <= 1'b0;
          mem_wr <= 1'b0;
          mem_data_oe <= 1'b0;
        end else begin
          acc_cnt_reg <= acc_cnt_reg - 4'h1;
        end
      end
    end
  end

  // Pointers: the first-stage pointer is trusted to sit in external data space
  always_comb begin
    src_load = 1'b0;
    src_val = EXT_UPPER_BASE;
    if (start && reg_wdata[CTRL_STAGE2]) begin
      src_load = 1'b1; // see RULE7
    end else if (state_reg == ST_PTR && acc_done_reg) begin
      src_load = 1'b1; // see RULE4
      src_val = rd_word_reg;
    end
    // One step per consumed table word; the table must fit its page half
    src_inc = acc_done_reg && (state_reg != ST_PTR) && (state_reg != ST_WR); // see RULE8
    // Destination word is still in the capture register when its access ends
    dst_load = (state_reg == ST_DEST) && acc_done_reg;
    dst_inc = (state_reg == ST_WR) && (acc_done_reg || skip_wr); // see RULE20
  end

  // Table walk
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      state_reg <= ST_IDLE;
      hdr_idx_reg <= 3'h0;
      size_left_reg <= 16'h0000;
      dst_page_reg <= 7'h00;
      data_reg <= 16'h0000;
      blocks_reg <= 16'h0000;
      done_reg <= 1'b0;
      bad_hdr_reg <= 1'b0;
      prot_hit_reg <= 1'b0;
      jump <= 1'b0;
      entry_addr <= 23'h000000;
    end else begin
      jump <= 1'b0;
      case (state_reg)
        ST_IDLE: begin
          if (start) begin
            done_reg <= 1'b0;
            bad_hdr_reg <= 1'b0;
            prot_hit_reg <= 1'b0;
            blocks_reg <= 16'h0000;
            hdr_idx_reg <= 3'h0;
            state_reg <= reg_wdata[CTRL_STAGE2] ? ST_HDR : ST_PTR;
          end
        end
        ST_PTR: begin
          if (acc_done_reg) begin
            state_reg <= ST_HDR;
          end
        end
        ST_HDR: begin
          if (acc_done_reg) begin
            hdr_idx_reg <= hdr_idx_reg + 3'h1;
            if (hdr_idx_reg == 3'h0 && rd_word_reg != TABLE_TAG) begin
              bad_hdr_reg <= 1'b1; // see RULE12
              state_reg <= ST_IDLE;
            end else if (hdr_idx_reg == HDR_LAST) begin
              state_reg <= ST_SIZE;
            end
          end
        end
        ST_SIZE: begin
          if (acc_done_reg) begin
            if (rd_word_reg == END_SIZE) begin
              state_reg <= foot_en_reg ? ST_FOOT : ST_JUMP; // see RULE18 RULE16
            end else begin
              size_left_reg <= rd_word_reg; // see RULE15
              blocks_reg <= blocks_reg + 16'h0001;
              state_reg <= ST_PAGE;
            end
          end
        end
        ST_PAGE: begin
          if (acc_done_reg) begin
            dst_page_reg <= rd_word_reg[6:0]; // see RULE15
            state_reg <= ST_DEST;
          end
        end
        ST_DEST: begin
          if (acc_done_reg) begin
            state_reg <= ST_RD;
          end
        end
        ST_RD: begin
          if (acc_done_reg) begin
            data_reg <= rd_word_reg;
            state_reg <= ST_WR;
          end
        end
        ST_WR: begin
          if (acc_done_reg || skip_wr) begin
            if (skip_wr) begin
              prot_hit_reg <= 1'b1; // see RULE11
            end
            size_left_reg <= size_left_reg - 16'h0001;
            state_reg <= (size_left_reg == 16'h0001) ? ST_SIZE : ST_RD;
          end
        end
        ST_FOOT: begin
          if (acc_done_reg) begin
            state_reg <= ST_JUMP;
          end
        end
        ST_JUMP: begin
          if (!stage2_reg || !ext_mem_flash_select) begin
            jump <= 1'b1; // see RULE17
            entry_addr <= {entry_hi_reg, entry_lo_reg}; // see RULE14
            done_reg <= 1'b1;
            state_reg <= ST_IDLE;
          end
        end
        default: state_reg <= ST_IDLE;
      endcase
    end
  end

  // External memory select
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      ext_mem_flash_select <= FLASH_RST; // see RULE9
    end else if (stage2_reg && need_rd && !acc_active_reg && !acc_done_reg) begin
      ext_mem_flash_select <= 1'b1; // see RULE10
    end else if (stage2_reg && need_wr && !acc_active_reg && !acc_done_reg) begin
      ext_mem_flash_select <= 1'b0; // see RULE10
    end else if (stage2_reg && state_reg == ST_JUMP) begin
      ext_mem_flash_select <= 1'b0; // see RULE21
    end
  end

  // Software and table-loaded registers
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      stage2_reg <= 1'b0;
      ptr_io_reg <= 1'b0;
      foot_en_reg <= 1'b0;
      src_page_reg <= SRC_PAGE_RST;
      wait_reg <= WAIT_RST;
      bank_reg <= BANK_RST;
      entry_hi_reg <= 7'h00;
      entry_lo_reg <= 16'h0000;
      prot_lo_reg <= PROT_LO_RST;
      prot_hi_reg <= PROT_HI_RST;
      footer_reg <= 16'h0000;
      intr_disable <= 1'b0;
      overlay <= 1'b0;
    end else if (start) begin
      stage2_reg <= reg_wdata[CTRL_STAGE2];
      ptr_io_reg <= reg_wdata[CTRL_PTR_IO];
      foot_en_reg <= reg_wdata[CTRL_FOOT_EN];
      wait_reg <= WAIT_RST; // see RULE19
      intr_disable <= 1'b1; // see RULE19
      overlay <= 1'b1; // see RULE19
    end else if (state_reg == ST_HDR && acc_done_reg) begin
      case (hdr_idx_reg)
        3'h1: wait_reg <= rd_word_reg; // see RULE13
        3'h2: bank_reg <= rd_word_reg; // see RULE13
        3'h3: entry_hi_reg <= rd_word_reg[6:0]; // see RULE14
        3'h4: entry_lo_reg <= rd_word_reg; // see RULE14
        default: ;
      endcase
    end else if (state_reg == ST_FOOT && acc_done_reg) begin
      footer_reg <= rd_word_reg; // see RULE16
    end else if (reg_wr && state_reg == ST_IDLE) begin
      case (reg_addr)
        OFF_SRC_PAGE: src_page_reg <= reg_wdata[2:0];
        OFF_WAIT: wait_reg <= reg_wdata;
        OFF_BANK: bank_reg <= reg_wdata;
        OFF_PROT_LO: prot_lo_reg <= reg_wdata;
        OFF_PROT_HI: prot_hi_reg <= reg_wdata;
        default: ;
      endcase
    end
  end

  // Read port, unmapped reads as zero
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      reg_rdata <= 16'h0000;
    end else if (reg_rd) begin
      case (reg_addr)
        OFF_CTRL: reg_rdata <= {12'h000, foot_en_reg, ptr_io_reg, stage2_reg, 1'b0};
        OFF_STATUS: reg_rdata <= {9'h000, overlay, intr_disable, ext_mem_flash_select,
                                  prot_hit_reg, bad_hdr_reg, done_reg,
                                  state_reg != ST_IDLE};
        OFF_SRC_PAGE: reg_rdata <= {13'h0000, src_page_reg};
        OFF_WAIT: reg_rdata <= wait_reg;
        OFF_BANK: reg_rdata <= bank_reg;
        OFF_ENTRY_HI: reg_rdata <= {9'h000, entry_hi_reg};
        OFF_ENTRY_LO: reg_rdata <= entry_lo_reg;
        OFF_BLOCKS: reg_rdata <= blocks_reg;
        OFF_PROT_LO: reg_rdata <= prot_lo_reg;
        OFF_PROT_HI: reg_rdata <= prot_hi_reg;
        OFF_FOOTER: reg_rdata <= footer_reg;
        default: reg_rdata <= 16'h0000;
      endcase
    end
  end

  default clocking cb @(posedge clock); endclocking
  default disable iff (!resetn);

  sequence strobe_min_s;
    mem_rd [*3];
  endsequence

  tag_check_a: assert property ( // see RULE12
    state_reg == ST_HDR && hdr_idx_reg == 3'h0 && acc_done_reg && rd_word_reg != TABLE_TAG
    |=> state_reg == ST_IDLE && bad_hdr_reg) else $error("bad tag not refused");
  size_end_a: assert property ( // see RULE18
    state_reg == ST_SIZE && acc_done_reg && rd_word_reg == END_SIZE
    |=> state_reg inside {ST_FOOT, ST_JUMP}) else $error("zero size did not end");
  flash_read_a: assert property ( // see RULE10
    stage2_reg && mem_rd |-> ext_mem_flash_select) else $error("read without flash");
  sram_write_a: assert property ( // see RULE10
    stage2_reg && mem_wr |-> !ext_mem_flash_select) else $error("write without sram");
  dest_prog_a: assert property ( // see RULE2
    mem_wr |-> mem_space == SP_PROG) else $error("write outside program space");
  src_step_a: assert property ( // see RULE20
    src_inc && !src_load |=> src_ptr == $past(src_ptr) + 16'h0001) else $error("src step");
  upper_half_a: assert property ( // see RULE7
    stage2_reg && mem_rd |-> mem_addr[15]) else $error("ext read in lower half");
  jump_sram_a: assert property ( // see RULE21
    jump && stage2_reg |-> !ext_mem_flash_select) else $error("jump with flash");
  read_hold_a: assert property ( // see RULE19
    $rose(mem_rd) |-> strobe_min_s) else $error("strobe too short");
  start_setup_a: assert property ( // see RULE19
    start |=> wait_reg == WAIT_RST && intr_disable && overlay) else $error("start setup");
  ptr_fetch_a: assert property ( // see RULE3
    state_reg == ST_PTR && mem_rd |-> mem_addr[15:0] == PTR_ADDR) else $error("ptr addr");
  wait_load_a: assert property ( // see RULE13
    state_reg == ST_HDR && hdr_idx_reg == 3'h1 && acc_done_reg
    |=> wait_reg == $past(rd_word_reg)) else $error("wait word not loaded");

endmodule

// ==== tb/btl_mem_model.sv ====
`timescale 1ns/1ps
module btl_mem_model
  import btl_pkg::*;
#(
  parameter int DELAY = 1
) (
  // Clock
  input wire logic clock,
  // Loader memory pins
  input wire logic [22:0] mem_addr,
  input wire logic [1:0] mem_space,
  input wire logic mem_rd,
  input wire logic mem_wr,
  input wire logic [15:0] mem_wdata,
  input wire logic mem_data_oe,
  input wire logic flash_sel,
  // Data pins back to the loader
  output logic [15:0] mem_rdata
);
  logic [15:0] rom [logic [24:0]];
  logic [15:0] ram [logic [24:0]];
  int rd_cnt = 0;
  int bad_cnt = 0;
  logic ext;
  logic [24:0] key;

  assign key = {mem_space, mem_addr};
  // Upper half of a page is external, lower half is overlaid RAM
  assign ext = mem_addr[15];
  initial mem_rdata = 16'h0000;

  // Idle pins toggle so stale data never passes for a fresh word
  // Falling edge, so a zero-wait read is ready at the next rising edge
  always @(negedge clock) begin
    if (mem_rd && rd_cnt + 1 >= DELAY && !(ext && !flash_sel)) begin
      mem_rdata <= rom.exists(key) ? rom[key] : 16'hFFFF;
    end else begin
      mem_rdata <= ~mem_rdata;
    end
    rd_cnt <= mem_rd ? rd_cnt + 1 : 0;
    if (mem_rd && ext && !flash_sel) begin
      bad_cnt <= bad_cnt + 1;
    end
    if (mem_wr && ((ext && flash_sel) || mem_data_oe !== 1'b1)) begin
      bad_cnt <= bad_cnt + 1;
    end else if (mem_wr) begin
      ram[key] = mem_wdata;
    end
  end
endmodule

// ==== tb/boot_table_loader_test.sv ====
`timescale 1ns/1ps
module boot_table_loader_test;
  import btl_pkg::*;
  logic clock = 1'b0;
  logic resetn = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [15:0] reg_wdata = 16'h0000;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [15:0] reg_rdata, mem_wdata, mem_rdata, rd;
  logic [22:0] mem_addr, entry_addr;
  logic [1:0] mem_space;
  logic mem_rd, mem_wr, mem_data_oe, ext_mem_flash_select, intr_disable, overlay, jump;
  logic [15:0] tbl [$];
  int error_cnt = 0;
  int check_count = 0;
  int jump_cnt = 0;

  btl_loader btl_loader_inst (
    .clock(clock), .resetn(resetn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .mem_addr(mem_addr),
    .mem_space(mem_space), .mem_rd(mem_rd), .mem_wr(mem_wr), .mem_wdata(mem_wdata),
    .mem_data_oe(mem_data_oe), .mem_rdata(mem_rdata),
    .ext_mem_flash_select(ext_mem_flash_select), .intr_disable(intr_disable),
    .overlay(overlay), .jump(jump), .entry_addr(entry_addr)
  );

  btl_mem_model #(.DELAY(1)) btl_mem_model_inst (
    .clock(clock), .mem_addr(mem_addr), .mem_space(mem_space), .mem_rd(mem_rd),
    .mem_wr(mem_wr), .mem_wdata(mem_wdata), .mem_data_oe(mem_data_oe),
    .flash_sel(ext_mem_flash_select), .mem_rdata(mem_rdata)
  );

  always #50 clock = ~clock;

  always @(posedge clock) begin
    if (jump === 1'b1) begin
      jump_cnt <= jump_cnt + 1;
    end
  end

  task automatic finish_test();
    if (error_cnt == 0 && check_count > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  task automatic check(input logic [22:0] got, input logic [22:0] exp);
    check_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic reg_write(input logic [7:0] a, input logic [15:0] d);
    @(posedge clock);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clock);
    reg_wr <= 1'b0;
  endtask

  // Read data are registered on the strobe edge and held until the next read
  task automatic reg_read(input logic [7:0] a);
    @(posedge clock);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clock);
    reg_rd <= 1'b0;
    #1 rd = reg_rdata;
  endtask

  task automatic expect_reg(input logic [7:0] a, input logic [15:0] exp);
    reg_read(a);
    check({7'h00, rd}, {7'h00, exp});
  endtask

  task automatic check_ram(input logic [22:0] a, input logic [15:0] exp);
    check({7'h00, btl_mem_model_inst.ram[{SP_PROG, a}]}, {7'h00, exp});
  endtask

  task automatic load(input logic [1:0] sp, input logic [22:0] base);
    foreach (tbl[i]) begin
      btl_mem_model_inst.rom[{sp, base + 23'(i)}] = tbl[i];
    end
  endtask

  // Start a load and poll until busy drops, bounded
  task automatic run(input logic [15:0] ctrl);
    int n;
    n = 0;
    reg_write(OFF_CTRL, ctrl);
    do begin
      reg_read(OFF_STATUS);
      n++;
    end while (rd[STAT_BUSY] !== 1'b0 && n < 3000);
    check({22'h0, rd[STAT_BUSY]}, 23'h0);
  endtask

  initial begin
    repeat (50000) @(posedge clock);
    error_cnt++;
    finish_test();
  end

  initial begin
    repeat (16) @(posedge clock);
    resetn <= 1'b1;
    check({22'h0, ext_mem_flash_select}, 23'h1);
    expect_reg(OFF_WAIT, WAIT_RST);
    expect_reg(OFF_SRC_PAGE, 16'h0001);
    expect_reg(8'h2C, 16'h0000);
    // First stage, pointer from data space, table above the hole
    tbl = '{16'h8000};
    load(SP_DATA, 23'h00FFFF);
    tbl = '{TABLE_TAG, 16'h0000, 16'h8806, 16'h0081, 16'h3705,
            16'h0002, 16'h0000, 16'h0100, 16'hA1A1, 16'hA2A2,
            16'h0001, 16'h0000, 16'h0200, 16'hB1B1, END_SIZE};
    load(SP_DATA, 23'h008000);
    run(16'h0001);
    check(entry_addr, 23'h013705);
    check(23'(jump_cnt), 23'h1);
    check({21'h0, intr_disable, overlay}, 23'h3);
    check_ram(23'h000100, 16'hA1A1);
    check_ram(23'h000101, 16'hA2A2);
    check_ram(23'h000200, 16'hB1B1);
    expect_reg(OFF_WAIT, 16'h0000);
    expect_reg(OFF_BANK, 16'h8806);
    expect_reg(OFF_BLOCKS, 16'h0002);
    // Pointer from I/O, footer enabled, extra high bits in entry page
    tbl = '{16'h9000};
    load(SP_IO, 23'h00FFFF);
    tbl = '{TABLE_TAG, 16'h0249, 16'h0000, 16'hFF85, 16'h0010,
            16'h0001, 16'h0000, 16'h0300, 16'hC3C3, END_SIZE, 16'h5A5A};
    load(SP_DATA, 23'h009000);
    run(16'h000D);
    check(entry_addr, 23'h050010);
    check_ram(23'h000300, 16'hC3C3);
    expect_reg(OFF_FOOTER, 16'h5A5A);
    // Wrong tag word 10ABh: no copy, no jump
    tbl = '{16'hA000};
    load(SP_DATA, 23'h00FFFF);
    tbl = '{16'h10AB, 16'h0000, 16'h0000, 16'h0000, 16'h0000, END_SIZE};
    load(SP_DATA, 23'h00A000);
    run(16'h0001);
    check({22'h0, rd[STAT_BAD_HDR]}, 23'h1);
    check(23'(jump_cnt), 23'h2);
    // Second stage from extended page 2 into external SRAM
    reg_write(OFF_SRC_PAGE, 16'h0002);
    tbl = '{TABLE_TAG, 16'h0000, 16'h0000, 16'h0001, 16'h8000,
            16'h0002, 16'h0001, 16'h8010, 16'hD1D1, 16'hD2D2,
            16'h0001, 16'h0000, 16'h0000, 16'hE1E1, END_SIZE};
    load(SP_PROG, 23'h028000);
    run(16'h0003);
    check(entry_addr, 23'h018000);
    check({22'h0, ext_mem_flash_select}, 23'h0);
    check_ram(23'h018010, 16'hD1D1);
    check_ram(23'h018011, 16'hD2D2);
    check(23'(btl_mem_model_inst.ram.exists({SP_PROG, 23'h0})), 23'h0);
    check({22'h0, rd[STAT_PROT_HIT]}, 23'h1);
    check(23'(btl_mem_model_inst.bad_cnt), 23'h0);
    finish_test();
  end
endmodule
